// ==== pkg/fsr_pkg.sv ====
package fsr_pkg;
  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ    = 50;
  localparam int TMR_W      = 24;
  localparam int PULSE_US   = 10;   // min_clear_pulse_width
  localparam int SELECT_US  = 10;   // clear_release_to_select_delay (host side)
  localparam int IDLE_US    = 35;   // recovery time for a reset that interrupts no operation (idle)
  localparam int DECODE_US  = 40;
  localparam int READ_US    = 35;
  localparam int PROG_US    = 310;
  localparam int SECTOR_MS  = 12;
  localparam int BLOCK_MS   = 25;
  localparam int CHIP_MS    = 100;
  localparam int STATUS_MS  = 40;
  localparam int SETTLE_US  = 1000; // supply_settle_delay, plain default
  localparam int PULSE_CYC  = PULSE_US * CLK_MHZ;
  localparam int SELECT_CYC = SELECT_US * CLK_MHZ;
  localparam int IDLE_CYC   = IDLE_US * CLK_MHZ;
  localparam int DECODE_CYC = DECODE_US * CLK_MHZ;
  localparam int READ_CYC   = READ_US * CLK_MHZ;
  localparam int PROG_CYC   = PROG_US * CLK_MHZ;
  localparam int SECTOR_CYC = SECTOR_MS * 1000 * CLK_MHZ;
  localparam int BLOCK_CYC  = BLOCK_MS * 1000 * CLK_MHZ;
  localparam int CHIP_CYC   = CHIP_MS * 1000 * CLK_MHZ;
  localparam int STATUS_CYC = STATUS_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  // ------------------------------------------------------------------
  // operation classes reported by the command core
  // ------------------------------------------------------------------
  localparam logic [2:0] OP_NONE   = 3'h0;
  localparam logic [2:0] OP_DECODE = 3'h1;
  localparam logic [2:0] OP_READ   = 3'h2;
  localparam logic [2:0] OP_PROG   = 3'h3;
  localparam logic [2:0] OP_SECTOR = 3'h4; // sector_erase_op
  localparam logic [2:0] OP_BLOCK  = 3'h5; // block_erase_op
  localparam logic [2:0] OP_CHIP   = 3'h6;
  localparam logic [2:0] OP_STATUS = 3'h7; // status_write_op
  // ------------------------------------------------------------------
  // register map and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  ADDR_STATUS = 8'h00;
  localparam logic [7:0]  ADDR_LOCK   = 8'h04;
  localparam logic [7:0]  ADDR_REMAIN = 8'h08;
  localparam logic [7:0]  LOCK_RESET  = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_POR     = 6'h01,
    ST_SETTLE  = 6'h02,
    ST_IDLE    = 6'h04,
    ST_PULSE   = 6'h08,
    ST_HELD    = 6'h10,
    ST_RECOVER = 6'h20
  } fsr_state_t;
endpackage

// ==== core/fsr_timer.sv ====
`timescale 1ns/1ps
// down counter shared by the settle and recovery waits
module fsr_timer #(
  parameter int W = 24
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] count,
  output logic              done
);
  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  assign done = (count == '0) && !load;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= '0;
    else if (load)
      count <= load_val;
    else if (count != '0)
      count <= count - 1'b1;
  end
endmodule

// ==== core/fsr_sequencer.sv ====
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Contract
// - a clear pulse low for at least 10 us resets; shorter pulses ignored
// - reset completion gives standby, clears write enable, write in progress, locks
// - a qualified reset during program or erase aborts it at once
// - while the clear pin is low, data output floats and activity drops
// - recovery: 40 us decode, 35 us read, 310 us program
// - recovery: 12 ms sector, 25 ms block, 100 ms chip erase, 40 ms status
// - power-up lands in standby with write enable latch cleared
// - commands accepted only after supply minimum plus settle delay
// - below the power-on threshold logic is held reset, commands ignored
module fsr_sequencer
  import fsr_pkg::*;
#(
  parameter int PROG_CYCLES   = PROG_CYC,
  parameter int SECTOR_CYCLES = SECTOR_CYC,
  parameter int BLOCK_CYCLES  = BLOCK_CYC,
  parameter int CHIP_CYCLES   = CHIP_CYC,
  parameter int STATUS_CYCLES = STATUS_CYC,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        supply_ok,
  input  wire logic        supply_min,
  input  wire logic        clear_n,
  input  wire logic        cs_n,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  op_class,
  input  wire logic        wel_set,
  input  wire logic        wel_clr,
  input  wire logic        wip_set,
  input  wire logic        wip_clr,
  output logic             cmd_accept,
  output logic             busy,
  output logic             standby,
  output logic             low_power,
  output logic             so_oe_n,
  output logic             abort_op,
  output logic             write_enable_latch,
  output logic             write_in_progress,
  output logic [7:0]       sram_lock,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  fsr_state_t         state;
  fsr_state_t         next_state;
  fsr_state_t         resume;
  logic [9:0]         pulse_cnt;
  logic [2:0]         held_op;
  logic [TMR_W-1:0]   tmr_count;
  logic               tmr_done;
  logic               tmr_load;
  logic [TMR_W-1:0]   tmr_val;
  logic [TMR_W-1:0]   recov_cyc;
  logic               qualify;
  logic               finish_rst;
  logic               op_destructive;
  logic               wr_go;
  logic               rd_go;
  logic               wr_lock;
  logic [31:0]        rd_word;
  logic               rd_hit;

  // ------------------------------------------------------------------
  // recovery time selection by interrupted operation
  // ------------------------------------------------------------------
  assign recov_cyc =
      (held_op == OP_DECODE) ? TMR_W'(DECODE_CYC)    :
      (held_op == OP_READ)   ? TMR_W'(READ_CYC)      :
      (held_op == OP_PROG)   ? TMR_W'(PROG_CYCLES)   :
      (held_op == OP_SECTOR) ? TMR_W'(SECTOR_CYCLES) :
      (held_op == OP_BLOCK)  ? TMR_W'(BLOCK_CYCLES)  :
      (held_op == OP_CHIP)   ? TMR_W'(CHIP_CYCLES)   :
      (held_op == OP_STATUS) ? TMR_W'(STATUS_CYCLES) :
                               TMR_W'(IDLE_CYC);
  // the timer holds length-1 so the wait lasts exactly the full count
  assign tmr_load = (next_state != state) &&
                    (next_state == ST_SETTLE || next_state == ST_RECOVER);
  assign tmr_val  = (next_state == ST_SETTLE) ? TMR_W'(SETTLE_CYCLES - 1)
                                               : recov_cyc - 1'b1;

  fsr_timer #(.W(TMR_W)) u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .count    (tmr_count),
    .done     (tmr_done)
  );

  // ------------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------------
  // the first low sample only enters the pulse state, so the count lags the low samples by two cycles
  assign qualify    = (state == ST_PULSE) && !clear_n &&
                      (pulse_cnt == 10'(PULSE_CYC - 2));
  assign finish_rst = (state == ST_HELD) && clear_n;
  assign op_destructive = write_in_progress || (op_class >= OP_PROG);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_POR:     next_state = supply_min ? ST_SETTLE : ST_POR;
      ST_SETTLE:  next_state = !clear_n ? ST_PULSE : (tmr_done ? ST_IDLE : ST_SETTLE);
      ST_IDLE:    next_state = !clear_n ? ST_PULSE : ST_IDLE;
      ST_PULSE:   next_state = qualify ? ST_HELD : (clear_n ? resume : ST_PULSE);
      ST_HELD:    next_state = clear_n ? ST_RECOVER : ST_HELD;
      ST_RECOVER: next_state = !clear_n ? ST_PULSE : (tmr_done ? ST_IDLE : ST_RECOVER);
      default:    next_state = ST_POR;
    endcase
    if (!supply_ok)
      next_state = ST_POR;
  end

  // ------------------------------------------------------------------
  // state, pulse width counter and captured operation
  // ------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state     <= ST_POR;
      resume    <= ST_IDLE;
      pulse_cnt <= '0;
      held_op   <= OP_NONE;
      abort_op  <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      pulse_cnt <= (state == ST_PULSE) ? pulse_cnt + 1'b1 : '0;
      if (state != ST_PULSE && next_state == ST_PULSE)
        resume <= state;   // a short pulse returns to the state it left; a settle or recovery wait restarts
      if (qualify)
        held_op <= write_in_progress && op_class < OP_PROG ? OP_PROG : op_class;
      abort_op  <= qualify && op_destructive;
    end
  end

  // ------------------------------------------------------------------
  // volatile bits: set wins over clear, reset completion clears all
  // ------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == ST_POR || finish_rst)
    begin
      write_enable_latch <= 1'b0;
      write_in_progress  <= 1'b0;
      sram_lock          <= LOCK_RESET;
    end
    else
    begin
      write_enable_latch <= wel_set || (write_enable_latch && !wel_clr);
      write_in_progress  <= (wip_set || (write_in_progress && !wip_clr)) && !qualify;
      if (wr_lock)
        sram_lock <= s_axi_wdata[7:0];
    end
  end

  // ------------------------------------------------------------------
  // pin side status
  // ------------------------------------------------------------------
  // output enable is a flop so the float begins cleanly at the pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      so_oe_n   <= 1'b1;
      low_power <= 1'b0;
    end
    else
    begin
      so_oe_n   <= !clear_n || !supply_ok || next_state != ST_IDLE || cs_n;
      low_power <= !clear_n && supply_ok;
    end
  end

  assign busy       = (state != ST_IDLE);
  assign standby    = (state == ST_IDLE);
  assign cmd_accept = standby && supply_ok && clear_n && !cs_n && cmd_valid;

  // ------------------------------------------------------------------
  // axi4-lite slave: write and read take one beat each, answer next cycle
  // ------------------------------------------------------------------
  assign wr_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign wr_lock = wr_go && s_axi_awaddr == ADDR_LOCK && s_axi_wstrb[0];
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go   = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;
  assign rd_hit  = s_axi_araddr == ADDR_STATUS || s_axi_araddr == ADDR_LOCK ||
                   s_axi_araddr == ADDR_REMAIN;
  assign rd_word =
      (s_axi_araddr == ADDR_STATUS) ? {23'h0, held_op, state != ST_POR, low_power,
                                       write_in_progress, write_enable_latch,
                                       standby, busy} :
      (s_axi_araddr == ADDR_LOCK)   ? {24'h0, sram_lock} :
      (s_axi_araddr == ADDR_REMAIN) ? {8'h0, tmr_count} : 32'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0;
    end
    else
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr == ADDR_LOCK) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  qual_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == ST_HELD) |-> $past(pulse_cnt) == 10'(PULSE_CYC - 2) && !$past(clear_n))
    else $error("reset taken without a full pulse");
  vol_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == ST_RECOVER) && $past(state) == ST_HELD |->
    !write_enable_latch && !write_in_progress && sram_lock == LOCK_RESET)
    else $error("volatile bits survive reset");
  abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    qualify && op_destructive |=> abort_op && !write_in_progress)
    else $error("running operation not aborted");
  so_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !clear_n && supply_ok |=> so_oe_n && low_power)
    else $error("output driven during clear pulse");
  recov_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == ST_RECOVER) |-> tmr_count == recov_cyc - 1'b1)
    else $error("wrong recovery length");
  power_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == ST_IDLE) && $past(state) == ST_SETTLE |-> !write_enable_latch)
    else $error("power up without cleared latch");
  por_deaf_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !supply_ok |=> state == ST_POR ##0 !cmd_accept)
    else $error("logic active below threshold");
  busy_deaf_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_RECOVER && !tmr_done |=> busy ##0 !cmd_accept)
    else $error("command taken during recovery");
endmodule

// ==== testbench/fsr_host_model.sv ====
`timescale 1ns/1ps
// host controller side: owns the clear pin and the chip select
module fsr_host_model
  import fsr_pkg::*;
(
  input  wire logic aclk,
  input  wire logic busy,
  output logic      clear_n,
  output logic      cs_n
);
  // both pins idle high so the device stays deselected at power-up
  initial {clear_n, cs_n} = 2'h3;
  // hold the clear pin low for n cycles; a real reset uses the minimum width
  task automatic clear_pulse(input int n);
    @(posedge aclk) clear_n <= 1'b0;
    repeat (n) @(posedge aclk);
    clear_n <= 1'b1;
  endtask
  // gap after release, then wait out recovery before selecting
  task automatic wait_ready();
    repeat (SELECT_CYC) @(posedge aclk);
    for (int i = 0; i < 5000 && busy; i++) @(posedge aclk);
  endtask
  // raw select; a caller may use it early on purpose to probe refusal
  task automatic set_cs(input logic v);
    @(posedge aclk) cs_n <= v;
  endtask
endmodule

// ==== testbench/flash_reset_poweron_sequencer_tb_top.sv ====
`timescale 1ns/1ps
module flash_reset_poweron_sequencer_tb_top
  import fsr_pkg::*;
;
  // ---------------------------------------------------------------
  // signals, expectations and bus tasks
  // ---------------------------------------------------------------
  localparam int REC [8] = '{IDLE_CYC, DECODE_CYC, READ_CYC, 40, 50, 60, 70, 80};
  logic        aclk, aresetn, supply_ok, supply_min, clear_n, cs_n, cmd_valid;
  logic        wel_set, wel_clr, wip_set, wip_clr, cmd_accept, busy, standby;
  logic        low_power, so_oe_n, abort_op, write_enable_latch, write_in_progress;
  logic [2:0]  op_class;
  logic [7:0]  sram_lock, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          errors, n_compared, n_abort;
  fsr_sequencer #(.PROG_CYCLES(REC[3]), .SECTOR_CYCLES(REC[4]), .BLOCK_CYCLES(REC[5]),
    .CHIP_CYCLES(REC[6]), .STATUS_CYCLES(REC[7]), .SETTLE_CYCLES(20)) dut (
    .aclk(aclk), .aresetn(aresetn), .supply_ok(supply_ok), .supply_min(supply_min),
    .clear_n(clear_n), .cs_n(cs_n), .cmd_valid(cmd_valid), .op_class(op_class),
    .wel_set(wel_set), .wel_clr(wel_clr), .wip_set(wip_set), .wip_clr(wip_clr),
    .cmd_accept(cmd_accept), .busy(busy), .standby(standby), .low_power(low_power),
    .so_oe_n(so_oe_n), .abort_op(abort_op), .write_enable_latch(write_enable_latch),
    .write_in_progress(write_in_progress), .sram_lock(sram_lock),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  fsr_host_model host (.aclk(aclk), .busy(busy), .clear_n(clear_n), .cs_n(cs_n));
  // recovery expected for each interrupted operation class
  function automatic int rec_cyc(input int op);
    return REC[op];
  endfunction
  // only program, erase and status write get aborted
  function automatic int abort_exp(input int op);
    return (op >= OP_PROG) ? 1 : 0;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog and sequence
  // ---------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // abort pulses are counted so a double or missing pulse shows
  always @(posedge aclk) if (abort_op === 1'b1) n_abort++;
  // the run needs about 15k cycles; a hang is cut well after that
  initial
  begin
    repeat (30000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  lk;
    int          n;
    void'($urandom(85752));
    {aresetn, supply_ok, supply_min, cmd_valid, wel_set, wel_clr, wip_set, wip_clr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, op_class} = '0;
    s_axi_wstrb = 4'hf;
    {errors, n_compared, n_abort} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // supply below threshold: an early select with a command is ignored
    host.set_cs(1'b0);
    cmd_valid <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({cmd_accept, busy, standby}, 3'h2);
    host.set_cs(1'b1);
    {supply_ok, supply_min} <= 2'h3;
    for (n = 0; n < 1000 && !standby; n++) @(posedge aclk);
    chk(n >= 18 && n <= 24, 1'b1);
    axi_rd(ADDR_STATUS, d, r);
    chk(d[5:0], 6'h22);
    chk(write_enable_latch, 1'b0);
    host.wait_ready();
    host.set_cs(1'b0);
    @(posedge aclk);
    chk(cmd_accept, 1'b1);
    @(posedge aclk);
    chk(so_oe_n, 1'b0);
    host.set_cs(1'b1);
    axi_wr(8'h10, 32'h0, r);
    chk(r, RESP_SLVERR);
    axi_rd(8'h0c, d, r);
    chk({d[7:0], r}, {8'h0, RESP_SLVERR});
    // a pulse shorter than the minimum must leave everything as it was
    @(posedge aclk) wel_set <= 1'b1;
    @(posedge aclk) wel_set <= 1'b0;
    host.clear_pulse(20 + $urandom % 400);
    repeat (4) @(posedge aclk);
    chk({standby, write_enable_latch, n_abort[0]}, 3'h6);
    // full reset interrupting each operation class in turn
    for (int op = 0; op < 8; op++)
    begin
      host.wait_ready();
      lk = 8'($urandom);
      axi_wr(ADDR_LOCK, {24'h0, lk}, r);
      chk(r, RESP_OKAY);
      axi_rd(ADDR_LOCK, d, r);
      chk({d[7:0], r}, {lk, RESP_OKAY});
      op_class <= op[2:0];
      wip_set <= (op >= OP_PROG);
      wel_set <= 1'b1;
      @(posedge aclk);
      {wip_set, wel_set} <= 2'h0;
      n_abort = 0;
      // first pulse is exactly the minimum width; the host selects early to probe refusal
      fork
        host.clear_pulse(op == 0 ? PULSE_CYC : PULSE_CYC + 2 + $urandom % 40);
        begin
          host.set_cs(1'b0);
          repeat (19) @(posedge aclk);
          chk({so_oe_n, low_power, busy, cmd_accept}, 4'he);
          host.set_cs(1'b1);
        end
      join
      chk(n_abort, abort_exp(op));
      for (n = 0; n < 3000 && !standby; n++) @(posedge aclk);
      chk(n >= rec_cyc(op) - 1 && n <= rec_cyc(op) + 4, 1'b1);
      chk({write_enable_latch, write_in_progress, sram_lock}, 10'h0);
      op_class <= OP_NONE;
    end
    // supply drop in mid-run puts the logic back under reset
    supply_ok <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({busy, standby, cmd_accept}, 3'h4);
    tally_and_finish();
  end
endmodule
